// [rtl/acc_cfg.svh]
// register offsets, field positions, reset values for the comparator control block
// assumes a 32-bit classic wishbone slave with byte addresses, one word per register
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// number of comparators
`define ACC_NUM 3
// byte offsets
`define ACC_OFF_CTL_BASE 8'h00
`define ACC_OFF_CTL_STEP 8'h04
`define ACC_OFF_STATUS 8'h0C
`define ACC_OFF_FLAG 8'h10
`define ACC_OFF_IEN 8'h14
`define ACC_OFF_IRQCTL 8'h18
// control field positions
`define ACC_CTL_ENABLE 7
`define ACC_CTL_PIN_OUT 6
`define ACC_CTL_INVERT 5
`define ACC_CTL_EVSEL_HI 4
`define ACC_CTL_EVSEL_LO 3
`define ACC_CTL_REF_SEL 2
// irq control field positions
`define ACC_IRQ_PERIPH 6
`define ACC_IRQ_GLOBAL 7
// reset values
`define ACC_CTL_RST 8'h1F
`define ACC_FLAG_RST 3'h0
`define ACC_IEN_RST 3'h0

`endif

// [rtl/acc_pkg.sv]
// types shared by the comparator control block
// field order of acc_ctl_s matches the control register bit layout
package acc_pkg;

	typedef enum logic [1:0] {
		ACC_EV_OFF = 2'h0,
		ACC_EV_RISE = 2'h1,
		ACC_EV_FALL = 2'h2,
		ACC_EV_ANY = 2'h3
	} acc_evsel_e;

	// one control register, bit 7 down to bit 0
	typedef struct packed {
		logic enable;
		logic cmp_pin_out_enable;
		logic cmp_out_invert;
		acc_evsel_e event_select;
		logic noninv_ref_select;
		logic [1:0] inv_channel_select;
	} acc_ctl_s;

	// controls handed to one analog comparator core
	typedef struct packed {
		logic power_en;
		logic noninv_ref_select;
		logic [1:0] inv_channel_select;
	} acc_ana_s;

endpackage

// [rtl/acc_sync.sv]
// two-stage synchroniser for the asynchronous comparator outputs
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps

module acc_sync #(
	parameter int W = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	genvar b;
	generate
		for (b = 0; b < W; b++)
		begin : g_bit
			logic meta_q;
			logic stab_q;
			// first flop feeds only the second one
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end
				else
				begin
					meta_q <= async_i[b];
					stab_q <= meta_q;
				end
			end
			assign sync_o[b] = stab_q;
		end
	endgenerate

endmodule

// [rtl/acc_edge.sv]
// transition detector for one polarity-adjusted comparator output
// assumes level_i is already synchronous to clk_i
`timescale 1ns/1ps

module acc_edge (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	input wire acc_pkg::acc_evsel_e evsel_i,
	output logic event_o
);

	logic prev_q;
	logic rise;
	logic fall;

	// previous level, cleared with the comparators off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prev_q <= 1'b0;
		else
			prev_q <= level_i;
	end

	assign rise = level_i & ~prev_q;
	assign fall = ~level_i & prev_q;

	// event selection per mode
	always_comb
	begin
		unique case (evsel_i)
			acc_pkg::ACC_EV_OFF: event_o = 1'b0;
			acc_pkg::ACC_EV_RISE: event_o = rise;
			acc_pkg::ACC_EV_FALL: event_o = fall;
			acc_pkg::ACC_EV_ANY: event_o = rise | fall;
		endcase
	end

endmodule

// [rtl/acc_top.sv]
// control and event logic around three analog comparators
// assumes a classic wishbone master and asynchronous comparator core outputs
//
// Contract
// - a comparator runs only while its enable bit is set; clear means off
// - two-bit select routes one of three pins or bandgap to inverting input
// - select 11 bandgap, 10 shared pin b, 01 pin c, 00 own default pin
// - reference select 0 picks pin a, 1 picks programmable reference
// - eight input combinations per comparator, each set independently
// - output high when non-inverting input is higher; invert bit flips it
// - outputs readable as read-only status, comparator 1 at bit 0
// - pin output enable routes output to remappable pin; tristate still gates
// - event select 01 flags rising, 10 flags falling transitions
// - event select 11 flags any change of output
// - event select 00 never sets the flag
// - transitions are detected on the polarity-adjusted output
// - flags stay set until written zero; writing one sets them
// - request needs flag, its enable, peripheral and global enables
// - selecting event select 11 sets the flag itself
// - reset returns all control registers to reset state, comparators off
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "acc_cfg.svh"

module acc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] cmp_raw_i,
	input wire logic [2:0] pin_tristate_bit_i,
	output acc_pkg::acc_ana_s [2:0] analog_ctl_o,
	output logic [2:0] remappable_pin_sel_o,
	output logic [2:0] remappable_pin_out_o,
	output logic [2:0] remappable_pin_oe_n_o,
	output logic irq_o
);

	acc_pkg::acc_ctl_s [2:0] ctl_q;
	logic [2:0] adj_q;
	logic [2:0] flag_q;
	logic [2:0] ien_q;
	logic periph_en_q;
	logic global_en_q;
	logic ack_q;
	logic [31:0] dat_q;
	acc_pkg::acc_ana_s [2:0] ana_q;
	logic [2:0] pin_sel_q;
	logic [2:0] pin_oe_n_q;
	logic irq_q;
	logic [2:0] sync;
	logic [2:0] event_hit;
	logic [2:0] cfg_set;
	logic [2:0] ctl_wr;
	logic wr;
	logic flag_wr;
	logic [31:0] rdata;

	// a write lands at the edge where the master sees ack
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
	assign flag_wr = wr & (wb_adr_i == `ACC_OFF_FLAG);

	// single-cycle wait: ack one edge after the request, then dropped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
	end

	// read mux, unmapped words read zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			`ACC_OFF_CTL_BASE: rdata = {24'h00_0000, ctl_q[0]};
			`ACC_OFF_CTL_BASE + `ACC_OFF_CTL_STEP: rdata = {24'h00_0000, ctl_q[1]};
			`ACC_OFF_CTL_BASE + 8'h08: rdata = {24'h00_0000, ctl_q[2]};
			`ACC_OFF_STATUS: rdata = {29'h0000_0000, adj_q};
			`ACC_OFF_FLAG: rdata = {29'h0000_0000, flag_q};
			`ACC_OFF_IEN: rdata = {29'h0000_0000, ien_q};
			`ACC_OFF_IRQCTL: rdata = {24'h00_0000, global_en_q, periph_en_q, 6'h00};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// read data captured with the ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_q <= 32'h0000_0000;
		else if (wb_cyc_i & wb_stb_i & ~ack_q)
			dat_q <= rdata;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	acc_sync #(
		.W(3)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(cmp_raw_i),
		.sync_o(sync)
	);

	genvar i;
	generate
		for (i = 0; i < `ACC_NUM; i++)
		begin : g_cmp
			assign ctl_wr[i] = wr &
				(wb_adr_i == `ACC_OFF_CTL_BASE + 8'(4 * i));
			assign cfg_set[i] = ctl_wr[i] &
				(wb_dat_i[`ACC_CTL_EVSEL_HI:`ACC_CTL_EVSEL_LO] == 2'h3);

			// control register, each comparator on its own word
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					ctl_q[i] <= `ACC_CTL_RST;
				else if (ctl_wr[i])
					ctl_q[i] <= wb_dat_i[7:0];
			end

			// polarity-adjusted output; a disabled comparator reads low
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					adj_q[i] <= 1'b0;
				else if (!ctl_q[i].enable)
					adj_q[i] <= 1'b0;
				else
					adj_q[i] <= sync[i] ^ ctl_q[i].cmp_out_invert;
			end

			// edges seen after the polarity stage
			acc_edge u_edge (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.level_i(adj_q[i]),
				.evsel_i(ctl_q[i].event_select),
				.event_o(event_hit[i])
			);

			// sticky flag, hardware set wins over a software clear
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					flag_q[i] <= 1'b0;
				// write zero clears, write one sets
				else if (flag_wr)
					flag_q[i] <= wb_dat_i[i] | event_hit[i] | cfg_set[i];
				else
					flag_q[i] <= flag_q[i] | event_hit[i] | cfg_set[i];
			end

			// analog core controls, registered straight to the pins
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					ana_q[i] <= '0;
				else
				begin
					// power follows enable, off is lowest current
					ana_q[i].power_en <= ctl_q[i].enable;
					ana_q[i].noninv_ref_select <= ctl_q[i].noninv_ref_select;
					// inverting mux select, encoding passed as is
					// 11 bandgap, 10 shared b, 01 c, 00 default
					ana_q[i].inv_channel_select <= ctl_q[i].inv_channel_select;
				end
			end

			// pin path: mux select plus driver enable
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					pin_sel_q[i] <= 1'b0;
					pin_oe_n_q[i] <= 1'b1;
				end
				else
				begin
					// tristate bit still gates the driver
					pin_sel_q[i] <= ctl_q[i].cmp_pin_out_enable;
					pin_oe_n_q[i] <= ~(ctl_q[i].cmp_pin_out_enable &
						~pin_tristate_bit_i[i]);
				end
			end
		end
	endgenerate

	// interrupt enables and gating bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ien_q <= `ACC_IEN_RST;
			periph_en_q <= 1'b0;
			global_en_q <= 1'b0;
		end
		else
		begin
			if (wr & (wb_adr_i == `ACC_OFF_IEN))
				ien_q <= wb_dat_i[2:0];
			if (wr & (wb_adr_i == `ACC_OFF_IRQCTL))
			begin
				periph_en_q <= wb_dat_i[`ACC_IRQ_PERIPH];
				global_en_q <= wb_dat_i[`ACC_IRQ_GLOBAL];
			end
		end
	end

	// request needs all three enables; flags set regardless
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else
			irq_q <= (|(flag_q & ien_q)) & periph_en_q & global_en_q;
	end

	assign analog_ctl_o = ana_q;
	assign remappable_pin_sel_o = pin_sel_q;
	assign remappable_pin_out_o = adj_q;
	assign remappable_pin_oe_n_o = pin_oe_n_q;
	assign irq_o = irq_q;

	// checks on the block's own outputs
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	generate
		for (i = 0; i < `ACC_NUM; i++)
		begin : g_chk
			// history from inside reset is not a real edge
			sequence rise_seen;
				!$past(rst_i) ##0 $rose(adj_q[i])
				##0 ctl_q[i].event_select == acc_pkg::ACC_EV_RISE;
			endsequence
			sequence fall_seen;
				!$past(rst_i) ##0 $fell(adj_q[i])
				##0 ctl_q[i].event_select == acc_pkg::ACC_EV_FALL;
			endsequence
			sequence any_seen;
				!$past(rst_i) ##0 !$stable(adj_q[i])
				##0 ctl_q[i].event_select == acc_pkg::ACC_EV_ANY;
			endsequence

			off_low_a: assert property (
				!ctl_q[i].enable |=> !adj_q[i] && !ana_q[i].power_en)
				else $error("disabled comparator still active");
			// outputs lag the control word by one cycle, not across reset
			inv_mux_a: assert property (
				!$past(rst_i) |->
				ana_q[i].inv_channel_select == $past(ctl_q[i].inv_channel_select))
				else $error("inverting select not forwarded");
			ref_sel_a: assert property (
				!$past(rst_i) |->
				ana_q[i].noninv_ref_select == $past(ctl_q[i].noninv_ref_select))
				else $error("reference select lost");
			sync_path_a: assert property (
				$past(ctl_q[i].enable & ~ctl_q[i].cmp_out_invert)
				|-> adj_q[i] == $past(cmp_raw_i[i], 3))
				else $error("output not three cycles behind raw");
			polarity_a: assert property (
				$past(ctl_q[i].enable & ctl_q[i].cmp_out_invert)
				|-> adj_q[i] == !$past(cmp_raw_i[i], 3))
				else $error("inverted output wrong");
			pin_route_a: assert property (
				!$past(rst_i) |->
				remappable_pin_sel_o[i] == $past(ctl_q[i].cmp_pin_out_enable) &&
				remappable_pin_oe_n_o[i] ==
				!$past(ctl_q[i].cmp_pin_out_enable & ~pin_tristate_bit_i[i]))
				else $error("pin driver gating wrong");
			rise_flag_a: assert property (
				rise_seen |=> flag_q[i])
				else $error("rising edge missed");
			fall_flag_a: assert property (
				fall_seen |=> flag_q[i])
				else $error("falling edge missed");
			any_flag_a: assert property (
				any_seen |=> flag_q[i])
				else $error("change missed");
			off_flag_a: assert property (
				ctl_q[i].event_select == acc_pkg::ACC_EV_OFF && !flag_q[i]
				&& !flag_wr && !cfg_set[i] |=> !flag_q[i])
				else $error("flag set with events off");
			flag_hold_a: assert property (
				flag_q[i] && !flag_wr |=> flag_q[i])
				else $error("flag dropped without a write");
			cfg_flag_a: assert property (
				cfg_set[i] |=> flag_q[i] && ctl_q[i].event_select == acc_pkg::ACC_EV_ANY)
				else $error("any-change select did not flag");
			reset_ctl_a: assert property (
				$past(rst_i) |-> ctl_q[i] == `ACC_CTL_RST)
				else $error("control not at reset value");
		end
	endgenerate

	irq_gate_a: assert property (
		!$past(rst_i) |->
		irq_o == $past((|(flag_q & ien_q)) & periph_en_q & global_en_q))
		else $error("interrupt gating wrong");
	ack_pulse_a: assert property (
		ack_q |=> !ack_q)
		else $error("ack held two cycles");

endmodule

// [verif/acc_cmp_model.sv]
// behavioural comparator cores and their analog inputs
// assumes voltages arrive as unsigned codes from the bench
`timescale 1ns/1ps

module acc_cmp_model (
	input wire logic clk_i,
	input wire acc_pkg::acc_ana_s [2:0] ana_i,
	input wire logic [2:0][7:0] pin_a_i,
	input wire logic [7:0] vref_i,
	input wire logic [2:0][3:0][7:0] inv_i,
	output logic [2:0] raw_o
);
	logic junk_q = 1'b0;
	logic [7:0] vp;
	logic [7:0] vn;

	// an unpowered core has no valid level, so it wanders
	always_ff @(posedge clk_i)
		junk_q <= ~junk_q;

	// every selected pin is taken as a configured analog input
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			vp = ana_i[i].noninv_ref_select ? vref_i : pin_a_i[i];
			vn = inv_i[i][ana_i[i].inv_channel_select];
			raw_o[i] = ana_i[i].power_en ? (vp > vn) : junk_q;
		end
	end
endmodule

// [verif/acc_top_tb.sv]
// self-checking bench for the comparator control block
// assumes the behavioural core model on the analog side
`timescale 1ns/1ps
`include "acc_cfg.svh"

module acc_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat = 32'h0, rdat, rd;
	logic [2:0] raw, psel, pout, poe_n;
	logic [2:0] ts = 3'h7;
	acc_pkg::acc_ana_s [2:0] ana;
	logic [2:0][7:0] pin_a = 24'h0;
	logic [7:0] vref = 8'hFF;
	// per core: select 0 and 2 low, 1 and 3 high
	logic [2:0][3:0][7:0] inv = {3{32'hC040C040}};
	int n_errors = 0, compares = 0, cycles = 0;

	acc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cmp_raw_i(raw),
		.pin_tristate_bit_i(ts), .analog_ctl_o(ana), .remappable_pin_sel_o(psel),
		.remappable_pin_out_o(pout), .remappable_pin_oe_n_o(poe_n), .irq_o(irq));

	acc_cmp_model cores (.clk_i(clk_i), .ana_i(ana), .pin_a_i(pin_a),
		.vref_i(vref), .inv_i(inv), .raw_o(raw));

	// clock, 5 ns period
	initial
		forever #2.5 clk_i = ~clk_i;

	task automatic end_of_test;
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, far above the expected run
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %0h seen %0h", s, exp, seen);
		end
	endtask

	// one classic cycle; held until ack is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		// no local limit: only the bench timeout ends a wait
		while (ack !== 1'b1)
			@(posedge clk_i);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic flag(input string s, input logic [31:0] e);
		bus(1'b0, `ACC_OFF_FLAG, 0);
		chk(s, rd, e);
		bus(1'b1, `ACC_OFF_FLAG, 0);
	endtask

	// main sequence
	initial
	begin
		wt(2);
		rst_i <= 1'b0;
		wt(1);
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b0, 8'(4 * i), 0);
			chk("ctl", rd, 32'h1F);
			chk("ana", ana[i], 4'h7);
		end
		pin_a <= {3{8'h80}};
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, 8'h00, 32'h80 | c);
			wt(8);
			chk("ana", ana[0], 4'h8 | c);
			bus(1'b0, `ACC_OFF_STATUS, 0);
			// one-bit expectation: odd selects meet the high input
			chk("sel", rd[0], c[2] | !c[0]);
		end
		pin_a[0] <= 8'h00;
		for (int e = 0; e < 4; e++)
		begin
			bus(1'b1, 8'h00, 32'h80 | (e << 3));
			wt(8);
			flag("mode", e == 3);
			pin_a[0] <= 8'h80;
			wt(8);
			flag("rise", e[0]);
			// software reads the level to tell which way it went
			bus(1'b0, `ACC_OFF_STATUS, 0);
			chk("level hi", rd, 1);
			pin_a[0] <= 8'h00;
			wt(8);
			flag("fall", e[1]);
			bus(1'b0, `ACC_OFF_STATUS, 0);
			chk("level lo", rd, 0);
		end
		bus(1'b1, 8'h00, 32'hA8);
		wt(8);
		bus(1'b0, `ACC_OFF_STATUS, 0);
		chk("inv", rd, 1);
		flag("inv on", 1);
		pin_a[0] <= 8'h80;
		wt(8);
		flag("inv rise", 0);
		pin_a[0] <= 8'h00;
		wt(8);
		flag("inv fall", 1);
		pin_a <= {8'h00, 8'h80, 8'h00};
		bus(1'b1, 8'h04, 32'h80);
		bus(1'b1, 8'h08, 32'h80);
		wt(8);
		bus(1'b1, `ACC_OFF_STATUS, 32'hFF);
		bus(1'b0, `ACC_OFF_STATUS, 0);
		chk("status", rd, 32'h3);
		bus(1'b0, 8'h1C, 0);
		chk("unmapped", rd, 0);
		bus(1'b1, `ACC_OFF_FLAG, 32'h7);
		for (int k = 0; k < 8; k++)
		begin
			bus(1'b1, `ACC_OFF_IEN, k[0]);
			bus(1'b1, `ACC_OFF_IRQCTL, {k[2:1], 6'h00});
			wt(3);
			chk("irq", irq, k == 7);
		end
		flag("sw set", 32'h7);
		wt(3);
		chk("irq off", irq, 0);
		ts <= 3'h6;
		pin_a[0] <= 8'h80;
		bus(1'b1, 8'h00, 32'hC0);
		wt(8);
		chk("pin", {psel, poe_n[0], pout[0]}, 5'h5);
		ts <= 3'h7;
		wt(3);
		chk("pin oe", poe_n[0], 1);
		bus(1'b1, 8'h00, 0);
		wt(8);
		chk("off", {ana[0].power_en, pout[0]}, 0);
		rst_i <= 1'b1;
		wt(3);
		rst_i <= 1'b0;
		wt(1);
		bus(1'b0, 8'h04, 0);
		chk("ctl", rd, 32'h1F);
		end_of_test();
	end
endmodule
